/* File: rtl/rpf_params.svh */
// Address map, field layout and packet constants of the report framer.
`ifndef RPF_PARAMS_SVH
`define RPF_PARAMS_SVH
// Register byte offsets; paddr[7] set selects the report memory window.
`define RPF_A_CTRL   8'h00
`define RPF_A_STAT   8'h04
`define RPF_A_SSRC   8'h08
`define RPF_A_PKTS   8'h0C
`define RPF_A_OCTS   8'h10
`define RPF_A_LSR    8'h14
`define RPF_A_RTT    8'h18
`define RPF_A_RXSRC  8'h1C
`define RPF_A_WIN    7
// Control register fields.
`define RPF_C_GO     0
`define RPF_C_KIND   2:1
`define RPF_C_RC     6:4
`define RPF_C_CLR    7
`define RPF_C_CNW    11:8
// Status register fields.
`define RPF_S_BUSY   0
`define RPF_S_SRSEEN 1
`define RPF_S_RXERR  2
`define RPF_S_RTTV   3
`define RPF_S_KIND   5:4
// Packet constants.
`define RPF_VER      2'h2
`define RPF_PT_SR    8'hC8
`define RPF_PT_RR    8'hC9
`define RPF_PT_SDES  8'hCA
`define RPF_CNAME    8'h01
`define RPF_HDR_W    6'h02
`define RPF_SI_W     6'h05
`define RPF_SR_BASE  6'h07
`define RPF_LAST_SUB 3'h5
`define RPF_LAST_BYT 2'h3
`define RPF_MAX_RC   3'h4
`define RPF_MAX_CNW  4'h8
`define RPF_CN_BASE  5'h18
`define RPF_MIN_OCT  16'h0008
`define RPF_RX_WSAT  8'hFF
`endif

/* File: rtl/rpf_pkg.sv */
// Types shared by the report framer files.
package rpf_pkg;
  typedef enum logic [1:0] {
    RPF_K_SR   = 2'b00,
    RPF_K_RR   = 2'b01,
    RPF_K_SDES = 2'b10,
    RPF_K_NONE = 2'b11
  } rpf_kind_t;
  typedef enum logic [1:0] {
    RPF_T_IDLE  = 2'b00,
    RPF_T_FETCH = 2'b01,
    RPF_T_LOAD  = 2'b10,
    RPF_T_SEND  = 2'b11
  } rpf_tx_t;
endpackage : rpf_pkg

/* File: rtl/rpf_mem.sv */
// Report block and description item memory with registered read data.
`timescale 1ns/10ps
`default_nettype none
module rpf_mem #(
  parameter int W  = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : rpf_mem
`default_nettype wire

/* File: rtl/rpf_framer.sv */
// Report packet framer: builds and parses SR, RR and SDES packets.
// Notes on behaviour
// R01: Sender Report opens with an eight-octet header, then sender info, blocks.
// R02: The 5-bit report count equals the number of report blocks carried.
// R03: Sender Report packet type is 200; incoming 200 is classed as SR.
// R04: Length field is packet size in 32-bit words minus one.
// R05: NTP field holds wall clock time at the moment of sending.
// R06: RTP timestamp field marks the same instant in media units.
// R07: A 32-bit count of media packets sent goes into each SR.
// R08: A 32-bit count of payload octets sent goes into each SR.
// R09: Each report block opens with the SSRC it describes.
// R10: Fraction lost is an 8-bit fully fractional unsigned value.
// R11: Cumulative loss is a 24-bit count per source.
// R12: Extended highest sequence: wrap count high, sequence low.
// R13: Jitter is a 32-bit unsigned value in timestamp units.
// R14: Last-SR field is NTP bits 47..16 of the latest SR received.
// R15: Delay since last SR counts 1/65536 s from that SR to now.
// R16: Receiver Report uses type 201 and drops the five sender-info words.
// R17: SDES uses type 202; its source count equals its chunk count.
// R18: An SDES chunk is one identifier followed by zero or more items.
// R19: Source descriptions carry a canonical name item.
// R20: Round trip delay is arrival time minus last-SR minus delay field.
// R21: Every header opens with the 2-bit version field.
// R22: With padding set, the last octet counts padding octets to drop.
// R23: Octets go out in numbered order, first octet first.
// R24: Fields go most significant octet first; short packets are rejected.
`timescale 1ns/10ps
`default_nettype none
`include "rpf_params.svh"
module rpf_framer #(
  parameter int MEM_AW = 5
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Media stream manager
  input  wire logic [63:0] ntp_time,
  input  wire logic [31:0] rtp_time,
  input  wire logic        media_pkt_sent,
  input  wire logic [15:0] media_payload_octets,
  // Outgoing report octets
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Incoming report octets
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  input  wire logic        rx_last,
  output logic      [1:0]  rx_kind,
  output logic             rx_good
);
  // ==========================================================
  // APB decode
  // ==========================================================
  wire        setup_q  = psel & penable & ~pready;
  wire        acc      = psel & penable & pready;
  wire        wr       = acc & pwrite;
  wire        in_win   = paddr[`RPF_A_WIN];
  wire        reg_ok   = (paddr[6:5] == 2'h0) & (paddr[1:0] == 2'h0);
  wire        hit      = (in_win & (paddr[1:0] == 2'h0)) | reg_ok;
  wire        wr_ctrl  = wr & ~in_win & (paddr == `RPF_A_CTRL);
  wire        wr_stat  = wr & ~in_win & (paddr == `RPF_A_STAT);
  wire        wr_ssrc  = wr & ~in_win & (paddr == `RPF_A_SSRC);
  wire        wr_mem   = wr & in_win & hit;
  wire        go       = wr_ctrl & pwdata[`RPF_C_GO];
  wire        clr_cnt  = wr_ctrl & pwdata[`RPF_C_CLR];
  wire [1:0]  go_kind  = pwdata[`RPF_C_KIND];
  wire [2:0]  go_rc    = pwdata[`RPF_C_RC];
  wire [3:0]  go_cnw   = pwdata[`RPF_C_CNW];

  logic [1:0]  kind_reg;
  logic [2:0]  rc_reg;
  logic [3:0]  cnw_reg;
  logic [31:0] ssrc_reg;
  logic [31:0] pkts_reg;
  logic [31:0] octs_reg;
  logic [31:0] lsr_reg;
  logic [31:0] arr_reg;
  logic [31:0] rtt_reg;
  logic [31:0] rxsrc_reg;
  logic        sr_seen_reg;
  logic        rtt_v_reg;
  logic        rx_err_reg;
  logic        busy;
  wire  [31:0] stat_word = {26'h0, rx_kind, rtt_v_reg, rx_err_reg,
                            sr_seen_reg, busy};
  wire  [31:0] ctrl_word = {20'h0, cnw_reg, 1'b0, rc_reg, 1'b0, kind_reg,
                            1'b0};
  wire  [31:0] rd_mux =
      in_win                    ? 32'h0 :
      (paddr == `RPF_A_CTRL)    ? ctrl_word :
      (paddr == `RPF_A_STAT)    ? stat_word :
      (paddr == `RPF_A_SSRC)    ? ssrc_reg :
      (paddr == `RPF_A_PKTS)    ? pkts_reg :
      (paddr == `RPF_A_OCTS)    ? octs_reg :
      (paddr == `RPF_A_LSR)     ? lsr_reg :
      (paddr == `RPF_A_RTT)     ? rtt_reg :
      (paddr == `RPF_A_RXSRC)   ? rxsrc_reg : 32'h0;

  // One wait state: the answer is prepared in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_q;
      prdata  <= setup_q ? rd_mux : 32'h0;
      pslverr <= setup_q & ~hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_reg <= 2'h0;
      rc_reg   <= 3'h0;
      cnw_reg  <= 4'h0;
      ssrc_reg <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        kind_reg <= pwdata[`RPF_C_KIND];
        rc_reg   <= pwdata[`RPF_C_RC];
        cnw_reg  <= pwdata[`RPF_C_CNW];
      end
      if (wr_ssrc) begin
        ssrc_reg <= pwdata;
      end
    end
  end

  // ==========================================================
  // Sender counters
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkts_reg <= 32'h0;
      octs_reg <= 32'h0;
    end else if (clr_cnt) begin
      pkts_reg <= 32'h0;
      octs_reg <= 32'h0;
    end else if (media_pkt_sent) begin
      pkts_reg <= pkts_reg + 32'h1;                          // [R07]
      octs_reg <= octs_reg + {16'h0, media_payload_octets};  // [R08]
    end
  end

  // ==========================================================
  // Transmit framer
  // ==========================================================
  rpf_pkg::rpf_tx_t   st_reg;
  rpf_pkg::rpf_kind_t k_s;
  logic [2:0]  rc_s;
  logic [3:0]  cnw_s;
  logic [5:0]  widx;
  logic [1:0]  bidx;
  logic [2:0]  blk;
  logic [2:0]  sub;
  logic [31:0] word_reg;
  logic [31:0] bssrc_reg;
  logic [63:0] ntp_s;
  logic [31:0] rtp_s;
  logic [31:0] pkts_s;
  logic [31:0] octs_s;
  logic [31:0] mem_rd;

  assign busy = (st_reg != rpf_pkg::RPF_T_IDLE);

  wire        is_sr   = (k_s == rpf_pkg::RPF_K_SR);
  wire        is_sdes = (k_s == rpf_pkg::RPF_K_SDES);
  wire [5:0]  rc6     = {3'h0, rc_s};
  wire [5:0]  blkw    = (rc6 << 2) + (rc6 << 1);
  wire [5:0]  n_words = is_sdes ? `RPF_HDR_W + {2'h0, cnw_s} :
                        `RPF_HDR_W + (is_sr ? `RPF_SI_W : 6'h0) + blkw;
  wire [5:0]  last_w  = n_words - 6'h1;
  wire [5:0]  blk_b   = is_sr ? `RPF_SR_BASE : `RPF_HDR_W;
  wire        in_blk  = (widx >= blk_b);
  wire [5:0]  cn_off  = widx - `RPF_HDR_W;
  wire [4:0]  blk_adr = {blk, 2'h0} + {1'b0, blk, 1'b0} + {2'h0, sub};
  wire [4:0]  rd_adr  = is_sdes ? `RPF_CN_BASE + cn_off[4:0] : blk_adr;
  wire [7:0]  pt_tx   = is_sr ? `RPF_PT_SR :                  // [R03]
                        is_sdes ? `RPF_PT_SDES : `RPF_PT_RR;  // [R16] [R17]
  wire [4:0]  cnt_tx  = is_sdes ? 5'h1 : {2'h0, rc_s};        // [R02] [R17]
  wire [31:0] hdr_w   = {`RPF_VER, 1'b0, cnt_tx, pt_tx,
                         {10'h0, last_w}};           // [R21] [R04] [R01]
  wire        own_lsr = sr_seen_reg & (bssrc_reg == rxsrc_reg);
  wire [31:0] dlsr    = ntp_s[47:16] - arr_reg;                // [R15]

  logic [31:0] tx_word;
  always_comb begin
    tx_word = mem_rd;                                // [R10] [R11] [R12] [R13]
    if (widx == 6'h0) begin
      tx_word = hdr_w;
    end else if (widx == 6'h1) begin
      tx_word = ssrc_reg;
    end else if (is_sdes) begin
      if (widx == `RPF_HDR_W) begin
        tx_word = {`RPF_CNAME, mem_rd[23:0]};        // [R18] [R19]
      end
    end else if (!in_blk) begin
      case (widx)
        6'h2:    tx_word = ntp_s[63:32];             // [R05]
        6'h3:    tx_word = ntp_s[31:0];
        6'h4:    tx_word = rtp_s;                    // [R06]
        6'h5:    tx_word = pkts_s;                   // [R07]
        default: tx_word = octs_s;                   // [R08]
      endcase
    end else if (own_lsr && sub == 3'h4) begin
      tx_word = lsr_reg;                             // [R14]
    end else if (own_lsr && sub == `RPF_LAST_SUB) begin
      tx_word = dlsr;                                // [R15]
    end
  end

  rpf_mem #(
    .W  (32),
    .AW (MEM_AW)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (wr_mem),
    .waddr   (paddr[MEM_AW+1:2]),
    .wdata   (pwdata),
    .raddr   (rd_adr),
    .rdata   (mem_rd)
  );

  wire tx_take = tx_valid & tx_ready;
  wire wd_end  = tx_take & (bidx == `RPF_LAST_BYT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= rpf_pkg::RPF_T_IDLE;
      widx   <= 6'h0;
      bidx   <= 2'h0;
      blk    <= 3'h0;
      sub    <= 3'h0;
    end else begin
      case (st_reg)
        rpf_pkg::RPF_T_IDLE: begin
          widx <= 6'h0;
          blk  <= 3'h0;
          sub  <= 3'h0;
          if (go) begin
            st_reg <= rpf_pkg::RPF_T_FETCH;
          end
        end
        rpf_pkg::RPF_T_FETCH: st_reg <= rpf_pkg::RPF_T_LOAD;
        rpf_pkg::RPF_T_LOAD: begin
          bidx   <= 2'h0;
          st_reg <= rpf_pkg::RPF_T_SEND;
        end
        rpf_pkg::RPF_T_SEND: begin
          if (tx_take) begin
            bidx <= bidx + 2'h1;
          end
          if (wd_end && widx == last_w) begin
            st_reg <= rpf_pkg::RPF_T_IDLE;
          end else if (wd_end) begin
            widx   <= widx + 6'h1;
            st_reg <= rpf_pkg::RPF_T_FETCH;
            if (in_blk && !is_sdes) begin
              sub <= (sub == `RPF_LAST_SUB) ? 3'h0 : sub + 3'h1;
              blk <= (sub == `RPF_LAST_SUB) ? blk + 3'h1 : blk;
            end
          end
        end
        default: st_reg <= rpf_pkg::RPF_T_IDLE;
      endcase
    end
  end

  // Snapshots freeze kind, block and item counts, times and sender counters at the send request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_s    <= rpf_pkg::RPF_K_SR;
      rc_s   <= 3'h0;
      cnw_s  <= 4'h0;
      ntp_s  <= 64'h0;
      rtp_s  <= 32'h0;
      pkts_s <= 32'h0;
      octs_s <= 32'h0;
    end else if (go && !busy) begin
      k_s    <= (go_kind == rpf_pkg::RPF_K_NONE) ? rpf_pkg::RPF_K_RR :
                rpf_pkg::rpf_kind_t'(go_kind);
      rc_s   <= (go_rc > `RPF_MAX_RC) ? `RPF_MAX_RC : go_rc;
      cnw_s  <= (go_cnw > `RPF_MAX_CNW) ? `RPF_MAX_CNW : go_cnw;
      ntp_s  <= ntp_time;                                    // [R05]
      rtp_s  <= rtp_time;                                    // [R06]
      pkts_s <= pkts_reg;
      octs_s <= octs_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg  <= 32'h0;
      bssrc_reg <= 32'h0;
      tx_data   <= 8'h0;
      tx_valid  <= 1'b0;
      tx_last   <= 1'b0;
    end else if (st_reg == rpf_pkg::RPF_T_LOAD) begin
      word_reg <= tx_word << 8;
      tx_data  <= tx_word[31:24];                            // [R23] [R24]
      tx_valid <= 1'b1;
      tx_last  <= 1'b0;
      if (in_blk && sub == 3'h0) begin
        bssrc_reg <= tx_word;                                // [R09]
      end
    end else if (wd_end) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end else if (tx_take) begin
      word_reg <= word_reg << 8;
      tx_data  <= word_reg[31:24];                           // [R23]
      tx_last  <= (bidx == 2'h2) & (widx == last_w);
    end
  end

  // ==========================================================
  // Receive parser
  // ==========================================================
  rpf_pkg::rpf_kind_t rk;
  logic [15:0] roc;
  logic [23:0] racc;
  logic [7:0]  rwidx;
  logic        rver_ok;
  logic        rpad;
  logic [4:0]  rcnt;
  logic [15:0] rlen;
  logic [31:0] rsrc;
  logic [2:0]  rblk;
  logic [2:0]  rsub;
  logic        rmatch;
  logic [31:0] rlsr_in;
  logic [31:0] c_lsr;
  logic [31:0] c_arr;
  logic [31:0] c_rtt;
  logic        c_rttv;
  logic        rend_q;
  logic        rok_q;

  wire [31:0] rw     = {racc, rx_data};                      // [R24]
  wire        rwd    = rx_valid & (roc[1:0] == `RPF_LAST_BYT);
  wire [31:0] now_m  = ntp_time[47:16];
  wire [7:0]  rbase  = (rk == rpf_pkg::RPF_K_SR) ? 8'h07 : 8'h02;
  wire        rrep   = (rk == rpf_pkg::RPF_K_SR) | (rk == rpf_pkg::RPF_K_RR);
  wire        rinblk = rrep & (rwidx >= rbase) & ({2'h0, rblk} < rcnt);
  wire [15:0] rtot   = roc + 16'h1;
  wire [17:0] rneed  = {rlen + 16'h1, 2'h0};                 // [R04]
  wire        rpadok = ~rpad | ((rx_data != 8'h0) &
                       ({8'h0, rx_data} <= rtot));           // [R22]
  wire        rok    = rver_ok & (rtot >= `RPF_MIN_OCT) &    // [R01]
                       ({2'h0, rtot} >= rneed) & rpadok;     // [R24]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rk <= rpf_pkg::RPF_K_NONE;
      roc <= 16'h0;
      racc <= 24'h0;
      rwidx <= 8'h0;
      rver_ok <= 1'b0;
      rpad <= 1'b0;
      rcnt <= 5'h0;
      rlen <= 16'h0;
      rsrc <= 32'h0;
      rblk <= 3'h0;
      rsub <= 3'h0;
      rmatch <= 1'b0;
      rlsr_in <= 32'h0;
      c_lsr <= 32'h0;
      c_arr <= 32'h0;
      c_rtt <= 32'h0;
      c_rttv <= 1'b0;
    end else if (rx_valid) begin
      roc  <= rx_last ? 16'h0 : rtot;
      racc <= {racc[15:0], rx_data};                         // [R23]
      if (rwd) begin
        rwidx <= (rwidx == `RPF_RX_WSAT) ? rwidx : rwidx + 8'h1;
        if (rwidx == 8'h0) begin
          rver_ok <= (rw[31:30] == `RPF_VER);                // [R21]
          rpad    <= rw[29];
          rcnt    <= rw[28:24];                              // [R02] [R17]
          rlen    <= rw[15:0];
          rk      <= (rw[23:16] == `RPF_PT_SR)   ? rpf_pkg::RPF_K_SR :  // [R03]
                     (rw[23:16] == `RPF_PT_RR)   ? rpf_pkg::RPF_K_RR :  // [R16]
                     (rw[23:16] == `RPF_PT_SDES) ? rpf_pkg::RPF_K_SDES :
                     rpf_pkg::RPF_K_NONE;
          rblk    <= 3'h0;
          rsub    <= 3'h0;
          c_rttv  <= 1'b0;
        end else if (rwidx == 8'h1) begin
          rsrc <= rw;
        end else if (rk == rpf_pkg::RPF_K_SR && rwidx == 8'h2) begin
          c_lsr[31:16] <= rw[15:0];                          // [R14]
        end else if (rk == rpf_pkg::RPF_K_SR && rwidx == 8'h3) begin
          c_lsr[15:0] <= rw[31:16];                          // [R14]
          c_arr       <= now_m;
        end else if (rinblk) begin
          rsub <= (rsub == `RPF_LAST_SUB) ? 3'h0 : rsub + 3'h1;
          rblk <= (rsub == `RPF_LAST_SUB) ? rblk + 3'h1 : rblk;
          if (rsub == 3'h0) begin
            rmatch <= (rw == ssrc_reg);                      // [R09]
          end else if (rsub == 3'h4) begin
            rlsr_in <= rw;
          end else if (rsub == `RPF_LAST_SUB && rmatch) begin
            c_rtt  <= now_m - rlsr_in - rw;                  // [R20]
            c_rttv <= 1'b1;
          end
        end
      end
      if (rx_last) begin
        rwidx <= 8'h0;
      end
    end
  end

  // Results are committed one cycle after the last octet.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rend_q      <= 1'b0;
      rok_q       <= 1'b0;
      rx_good     <= 1'b0;
      rx_kind     <= 2'h3;
      lsr_reg     <= 32'h0;
      arr_reg     <= 32'h0;
      rxsrc_reg   <= 32'h0;
      sr_seen_reg <= 1'b0;
      rtt_reg     <= 32'h0;
      rtt_v_reg   <= 1'b0;
      rx_err_reg  <= 1'b0;
    end else begin
      rend_q  <= rx_valid & rx_last;
      rok_q   <= rok;
      rx_good <= rend_q & rok_q;
      if (rend_q & rok_q) begin
        rx_kind <= rk;
        if (rk == rpf_pkg::RPF_K_SR) begin
          lsr_reg     <= c_lsr;                              // [R14]
          arr_reg     <= c_arr;                              // [R15]
          rxsrc_reg   <= rsrc;
          sr_seen_reg <= 1'b1;
        end
        if (c_rttv) begin
          rtt_reg   <= c_rtt;                                // [R20]
          rtt_v_reg <= 1'b1;
        end
      end
      // Error flag: a new error wins over a write-one clear.
      rx_err_reg <= (rend_q & ~rok_q) |                      // [R24]
                    (rx_err_reg & ~(wr_stat & pwdata[`RPF_S_RXERR]));
    end
  end
endmodule : rpf_framer
`default_nettype wire

/* File: verification/rpf_peer.sv */
// Octet sink standing for the remote report receiver.
`timescale 1ns/10ps
`default_nettype none
module rpf_peer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Octet stream from the framer
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Pace select
  input  wire logic       slow
);
  logic [7:0] got[$];
  int         last;
  logic [1:0] ph;
  // =====
  // Slow mode accepts only one edge in four.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      ph <= 2'h0;
    end else begin
      ph <= ph + 2'h1;
      tx_ready <= !slow || ph == 2'h3;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_last) last = got.size() - 1;
      end
    end
  end
endmodule : rpf_peer
`default_nettype wire

/* File: verification/rpf_framer_properties.sv */
// Port checks of the report framer.
`timescale 1ns/10ps
`default_nettype none
module rpf_framer_properties (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Octet streams
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        rx_good
);
  logic first_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) first_q <= 1'b1;
    else if (tx_valid && tx_ready) first_q <= tx_last;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  sequence s_wait; !pready ##1 pready; endsequence
  sequence s_hold;
    tx_valid && $stable(tx_data) && $stable(tx_last);
  endsequence
  a_one_wait: assert property ($rose(penable) && psel |-> s_wait)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> s_hold)
    else $error("octet changed before accepted");
  a_last_valid: assert property (tx_last |-> tx_valid)
    else $error("last flag without octet");
  a_first_hdr: assert property (tx_valid && first_q |->
    tx_data[7:5] == 3'h4 && tx_data[4:0] <= 5'h04)
    else $error("bad first header octet");
  a_good_cause: assert property (rx_good |-> $past(rx_valid && rx_last, 2))
    else $error("good flag without packet end");
  a_good_pulse: assert property (rx_good |=> !rx_good)
    else $error("good flag longer than one cycle");
endmodule : rpf_framer_properties
bind rpf_framer rpf_framer_properties u_props (.pclk, .presetn, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .tx_data, .tx_valid,
  .tx_last, .tx_ready, .rx_valid, .rx_last, .rx_good);
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the report framer.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, tx_data, rx_data;
  logic [31:0] pwdata, prdata, rd, rtp_time;
  logic [63:0] ntp_time;
  logic [15:0] media_payload_octets;
  logic        media_pkt_sent, tx_valid, tx_last, tx_ready, slow;
  logic        rx_valid, rx_last, rx_good;
  logic [1:0]  rx_kind;
  logic [31:0] ew[$];
  int          n_fail, total_checks, cyc, ngood;
  rpf_framer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ntp_time, .rtp_time,
    .media_pkt_sent, .media_payload_octets, .tx_data, .tx_valid,
    .tx_last, .tx_ready, .rx_data, .rx_valid, .rx_last, .rx_kind,
    .rx_good);
  rpf_peer peer (.pclk, .presetn, .tx_data, .tx_valid, .tx_last,
    .tx_ready, .slow);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) if (rx_good === 1'b1) ngood++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      give_verdict;
    end
  end
  // =====
  task chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  function logic [31:0] hdr(logic [4:0] c, logic [7:0] t, logic [15:0] l);
    return {3'h4, c, t, l};
  endfunction : hdr
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task tx_pkt(input logic [31:0] c, input bit again);
    int n;
    n = 0;
    peer.got.delete();
    apb(1'b1, 8'h00, c);
    if (again) apb(1'b1, 8'h00, c);
    while (peer.got.size() < 4 * ew.size() && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    repeat (20) @(posedge pclk);
    chk(4 * ew.size(), peer.got.size());
    chk(4 * ew.size() - 1, peer.last);
    foreach (ew[i])
      for (int j = 0; j < 4; j++) chk(ew[i][31-8*j -: 8], peer.got[4*i+j]);
  endtask : tx_pkt
  task send(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= ew[i/4][31-8*(i%4) -: 8];
      rx_last <= (i == n - 1);
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
    repeat (4) @(posedge pclk);
  endtask : send
  task bad(input int n);
    send(n);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'h06, rd);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'h02, rd);
  endtask : bad
  // =====
  task t_regs;
    apb(1'b0, 8'h04, 32'h0);
    chk(32'h30, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'h1, er);
    apb(1'b0, 8'h09, 32'h0);
    chk(32'h1, er);
    apb(1'b1, 8'h08, 32'h0A0B0C0D);
    apb(1'b0, 8'h08, 32'h0);
    chk(32'h0A0B0C0D, rd);
    apb(1'b1, 8'h0C, 32'hFF);
    apb(1'b0, 8'h0C, 32'h0);
    chk(32'h0, rd);
    $display("test regs done");
  endtask : t_regs
  task t_sr;
    for (int i = 1; i <= 3; i++) begin
      @(posedge pclk);
      media_pkt_sent <= 1'b1;
      media_payload_octets <= 16'(100 * i);
      @(posedge pclk);
      media_pkt_sent <= 1'b0;
    end
    for (int i = 0; i < 24; i++) apb(1'b1, 8'(128 + 4 * i), 32'h50000000 + i);
    ew = '{hdr(5'h1, 8'hC8, 16'hC), 32'h0A0B0C0D, ntp_time[63:32],
      ntp_time[31:0], rtp_time, 32'h3, 32'h258};
    for (int i = 0; i < 6; i++) ew.push_back(32'h50000000 + i);
    tx_pkt(32'h11, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'h258, rd);
    $display("test sr done");
  endtask : t_sr
  task t_rr;
    slow <= 1'b0;
    ew = '{hdr(5'h4, 8'hC9, 16'h19), 32'h0A0B0C0D};
    for (int i = 0; i < 24; i++) ew.push_back(32'h50000000 + i);
    tx_pkt(32'h73, 1'b1);
    $display("test rr done");
  endtask : t_rr
  task t_sdes;
    apb(1'b1, 8'hE0, 32'hFFAABBCC);
    ew = '{hdr(5'h1, 8'hCA, 16'h2), 32'h0A0B0C0D, 32'h01AABBCC};
    tx_pkt(32'h105, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    chk(32'h104, rd);
    $display("test sdes done");
  endtask : t_sdes
  task t_rx;
    int g;
    g = ngood;
    ew = '{hdr(5'h0, 8'hC8, 16'h6), 32'h5EED0001, 32'h11223344,
      32'h55667788, 32'h1, 32'h2, 32'h3};
    send(28);
    chk(g + 1, ngood);
    chk(32'h0, rx_kind);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'h33445566, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'h5EED0001, rd);
    bad(24);
    bad(6);
    ew[0] = hdr(5'h0, 8'hC8, 16'h7);
    bad(28);
    ew[0] = 32'h40C80006;
    bad(28);
    chk(g + 1, ngood);
    $display("test rx done");
  endtask : t_rx
  task t_rtt;
    ew = '{hdr(5'h1, 8'hC9, 16'h7), 32'h77, 32'h0A0B0C0D, 32'h1,
      32'h2, 32'h3, 32'h45000000, 32'h00010000};
    send(32);
    chk(32'h1, rx_kind);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'h1A, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk(ntp_time[47:16] - 32'h45000000 - 32'h00010000, rd);
    $display("test rtt done");
  endtask : t_rtt
  task t_lsr;
    apb(1'b1, 8'h80, 32'h5EED0001);
    ntp_time <= ntp_time + 64'h10000;
    ew = '{hdr(5'h1, 8'hC9, 16'h7), 32'h0A0B0C0D, 32'h5EED0001,
      32'h50000001, 32'h50000002, 32'h50000003, 32'h33445566, 32'h1};
    tx_pkt(32'h13, 1'b0);
    $display("test lsr done");
  endtask : t_lsr
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {media_pkt_sent, media_payload_octets, rx_data, rx_valid} = '0;
    rx_last = 1'b0;
    slow = 1'b1;
    ntp_time = 64'h0123456789ABCDEF;
    rtp_time = 32'h00C0FFEE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_sr;
    t_rr;
    t_sdes;
    t_rx;
    t_rtt;
    t_lsr;
    give_verdict;
  end
endmodule : tb_top
`default_nettype wire
